// ---- logic/fdsm_pkg.sv ----
// package: register map, field positions and reset values of the amplitude watch block
package fdsm_pkg;
  localparam int unsigned IDX_W = 10;
  // printed offsets are register indexes, byte address = 4 * index
  localparam logic [9:0] IDX_FD_CTRL     = 10'h245;
  localparam logic [9:0] IDX_FD_UP_LO    = 10'h247;
  localparam logic [9:0] IDX_FD_UP_HI    = 10'h248;
  localparam logic [9:0] IDX_FD_LOW_LO   = 10'h249;
  localparam logic [9:0] IDX_FD_LOW_HI   = 10'h24a;
  localparam logic [9:0] IDX_FD_DWELL_LO = 10'h24b;
  localparam logic [9:0] IDX_FD_DWELL_HI = 10'h24c;
  localparam logic [9:0] IDX_MON_SYNC    = 10'h26f;
  localparam logic [9:0] IDX_MON_CTRL    = 10'h270;
  localparam logic [9:0] IDX_MON_PER0    = 10'h271;
  localparam logic [9:0] IDX_MON_PER1    = 10'h272;
  localparam logic [9:0] IDX_MON_PER2    = 10'h273;
  localparam logic [9:0] IDX_IRQ_STATUS  = 10'h280;
  localparam logic [9:0] IDX_IRQ_MASK    = 10'h281;
  localparam logic [9:0] IDX_PEAK_LO     = 10'h282;
  localparam logic [9:0] IDX_PEAK_HI     = 10'h283;

  localparam int unsigned MAG_W   = 13;
  localparam int unsigned DWELL_W = 16;
  localparam int unsigned PER_W   = 24;
  localparam int unsigned HI_W    = 5;

  // fast detect control bits
  localparam int unsigned FD_EN_BIT    = 0;
  localparam int unsigned FD_FVAL_BIT  = 2;
  localparam int unsigned FD_FORCE_BIT = 3;
  // monitor sync control bits
  localparam int unsigned SYNC_EN_BIT   = 0;
  localparam int unsigned SYNC_NEXT_BIT = 1;
  // monitor control bits
  localparam int unsigned PEAK_EN_BIT = 1;
  // interrupt status / mask bits
  localparam int unsigned IRQ_W        = 3;
  localparam int unsigned IRQ_FLAG_BIT = 0;
  localparam int unsigned IRQ_SYNC_BIT = 1;
  localparam int unsigned IRQ_PER_BIT  = 2;

  localparam logic [7:0]       RST_BYTE   = 8'h00;
  localparam logic [PER_W-1:0] RST_PERIOD = 24'h000080;
  localparam logic [PER_W-1:0] MIN_PERIOD = 24'h000002;
endpackage : fdsm_pkg

// ---- logic/fdsm_reg_if.sv ----
// interface: register access strobes between the bus slave and the register file
`timescale 1ns/1ps
interface fdsm_reg_if;
  logic       wr_en;
  logic [9:0] wr_idx;
  logic [7:0] wr_data;
  logic [9:0] rd_idx;
  logic [7:0] rd_data;
  modport slave (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport regs  (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : fdsm_reg_if

// ---- logic/fdsm_ahb_slave.sv ----
// module: zero-wait AHB-Lite slave turning word accesses into byte register strobes
`timescale 1ns/1ps
module fdsm_ahb_slave (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // ahb-lite
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [31:0] i_hwdata,
  output logic      [31:0] o_hrdata,
  // register side
  fdsm_reg_if.slave        reg_bus
);
  logic       accept;
  logic       mapped;
  logic       wr_pend_r;
  logic [9:0] wr_idx_r;

  // upper address bits must be zero, otherwise the access hits nothing
  assign mapped          = (i_haddr[31:12] == 20'h00000);
  assign accept          = i_hsel && i_htrans[1];
  assign reg_bus.rd_idx  = i_haddr[11:2];
  assign reg_bus.wr_en   = wr_pend_r;
  assign reg_bus.wr_idx  = wr_idx_r;
  assign reg_bus.wr_data = i_hwdata[7:0];

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 10'h000;
    end else begin
      wr_pend_r <= accept && i_hwrite && mapped;
      wr_idx_r  <= i_haddr[11:2];
    end
  end

  // read data is looked up in the address phase so it stands from a flop in the data phase
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_hrdata <= 32'h00000000;
    end else if (accept && !i_hwrite) begin
      o_hrdata <= mapped ? {24'h000000, reg_bus.rd_data} : 32'h00000000;
    end
  end
endmodule : fdsm_ahb_slave

// ---- logic/fdsm_fast_detect.sv ----
// module: threshold comparator with dwell-timed release of the amplitude flag
`timescale 1ns/1ps
module fdsm_fast_detect (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // settings
  input  wire logic        i_enable,
  input  wire logic [12:0] i_upper,
  input  wire logic [12:0] i_lower,
  input  wire logic [15:0] i_dwell,
  // sample and result
  input  wire logic [12:0] i_magnitude,
  output logic             o_flag
);
  logic [15:0] dwell_r;

  always_ff @(posedge i_clk) begin
    if (i_reset || !i_enable) begin
      o_flag  <= 1'b0;
      dwell_r <= 16'h0000;
    end else if (i_magnitude > i_upper) begin
      o_flag  <= 1'b1;
      dwell_r <= i_dwell;
    end else if (i_magnitude >= i_lower) begin
      dwell_r <= i_dwell;
    end else if (dwell_r == 16'h0000) begin
      o_flag  <= 1'b0;
    end else begin
      dwell_r <= dwell_r - 16'h0001;
    end
  end
endmodule : fdsm_fast_detect

// ---- logic/fdsm_top.sv ----
// module: amplitude flag and signal monitor block with its register file on AHB-Lite
`timescale 1ns/1ps
module fdsm_top (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic [2:0]  i_hsize,
  input  wire logic        i_hwrite,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hwdata,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // converter side
  input  wire logic [12:0] i_magnitude,
  input  wire logic        i_sysref,
  input  wire logic        i_sysref_en,
  // pins and interrupt
  output logic             o_amp_flag_out_a,
  output logic             o_irq
);
  fdsm_reg_if reg_bus ();

  logic [7:0]  fd_ctrl_r;
  logic [7:0]  up_lo_r;
  logic [4:0]  up_hi_r;
  logic [7:0]  low_lo_r;
  logic [4:0]  low_hi_r;
  logic [7:0]  dwell_lo_r;
  logic [7:0]  dwell_hi_r;
  logic [1:0]  sync_ctrl_r;
  logic        peak_en_r;
  logic [23:0] period_r;
  logic [2:0]  irq_status_r;
  logic [2:0]  irq_status_nxt;
  logic [2:0]  irq_mask_r;
  logic [2:0]  irq_event;
  logic [12:0] peak_acc_r;
  logic [12:0] peak_res_r;
  logic [23:0] per_cnt_r;
  logic        sysref_s1_r;
  logic        sysref_s2_r;
  logic        sysref_s3_r;
  logic        sync_edge;
  logic        sync_hit;
  logic        per_end;
  logic        fd_flag;
  logic        fd_flag_d_r;
  logic [23:0] period_eff;
  logic [12:0] peak_now;
  logic [7:0]  rd_data;

  // hsize is single words only, so it carries no decode
  fdsm_ahb_slave u_slave (
    .i_clk    (i_clk),
    .i_reset  (i_reset),
    .i_hsel   (i_hsel && i_hready),
    .i_haddr  (i_haddr),
    .i_htrans (i_htrans),
    .i_hwrite (i_hwrite),
    .i_hwdata (i_hwdata),
    .o_hrdata (o_hrdata),
    .reg_bus  (reg_bus)
  );

  fdsm_fast_detect u_fd (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_enable    (fd_ctrl_r[fdsm_pkg::FD_EN_BIT]),
    .i_upper     ({up_hi_r, up_lo_r}),
    .i_lower     ({low_hi_r, low_lo_r}),
    .i_dwell     ({dwell_hi_r, dwell_lo_r}),
    .i_magnitude (i_magnitude),
    .o_flag      (fd_flag)
  );

  function automatic logic wr_hit(input logic [9:0] idx);
    wr_hit = reg_bus.wr_en && (reg_bus.wr_idx == idx);
  endfunction : wr_hit

  // always zero-wait, always okay
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
  end

  // threshold and dwell registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      fd_ctrl_r  <= fdsm_pkg::RST_BYTE;
      up_lo_r    <= fdsm_pkg::RST_BYTE;
      up_hi_r    <= fdsm_pkg::RST_BYTE[4:0];
      low_lo_r   <= fdsm_pkg::RST_BYTE;
      low_hi_r   <= fdsm_pkg::RST_BYTE[4:0];
      dwell_lo_r <= fdsm_pkg::RST_BYTE;
      dwell_hi_r <= fdsm_pkg::RST_BYTE;
    end else begin
      if (wr_hit(fdsm_pkg::IDX_FD_CTRL)) begin
        fd_ctrl_r <= reg_bus.wr_data & 8'h0d;
      end
      if (wr_hit(fdsm_pkg::IDX_FD_UP_LO)) begin
        up_lo_r <= reg_bus.wr_data;
      end
      if (wr_hit(fdsm_pkg::IDX_FD_UP_HI)) begin
        up_hi_r <= reg_bus.wr_data[4:0];
      end
      if (wr_hit(fdsm_pkg::IDX_FD_LOW_LO)) begin
        low_lo_r <= reg_bus.wr_data;
      end
      if (wr_hit(fdsm_pkg::IDX_FD_LOW_HI)) begin
        low_hi_r <= reg_bus.wr_data[4:0];
      end
      if (wr_hit(fdsm_pkg::IDX_FD_DWELL_LO)) begin
        dwell_lo_r <= reg_bus.wr_data;
      end
      if (wr_hit(fdsm_pkg::IDX_FD_DWELL_HI)) begin
        dwell_hi_r <= reg_bus.wr_data;
      end
    end
  end

  // monitor control and period registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      peak_en_r <= 1'b0;
      period_r  <= fdsm_pkg::RST_PERIOD;
    end else begin
      if (wr_hit(fdsm_pkg::IDX_MON_CTRL)) begin
        peak_en_r <= reg_bus.wr_data[fdsm_pkg::PEAK_EN_BIT];
      end
      if (wr_hit(fdsm_pkg::IDX_MON_PER0)) begin
        period_r[7:0] <= reg_bus.wr_data;
      end
      if (wr_hit(fdsm_pkg::IDX_MON_PER1)) begin
        period_r[15:8] <= reg_bus.wr_data;
      end
      if (wr_hit(fdsm_pkg::IDX_MON_PER2)) begin
        period_r[23:16] <= reg_bus.wr_data;
      end
    end
  end

  // sync control: a software write in the same cycle wins over the hardware clear
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sync_ctrl_r <= 2'h0;
    end else if (wr_hit(fdsm_pkg::IDX_MON_SYNC)) begin
      sync_ctrl_r <= reg_bus.wr_data[1:0];
    end else if (sync_hit && sync_ctrl_r[fdsm_pkg::SYNC_NEXT_BIT]) begin
      sync_ctrl_r[fdsm_pkg::SYNC_EN_BIT] <= 1'b0;
    end
  end

  // sysref pin crosses two flops; the third only feeds the edge detector
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sysref_s1_r <= 1'b0;
      sysref_s2_r <= 1'b0;
      sysref_s3_r <= 1'b0;
    end else begin
      sysref_s1_r <= i_sysref;
      sysref_s2_r <= sysref_s1_r;
      sysref_s3_r <= sysref_s2_r;
    end
  end

  assign sync_edge = sysref_s2_r && !sysref_s3_r && i_sysref_en;
  // once bit 0 clears in next mode, later edges fall through unused
  assign sync_hit  = sync_edge && sync_ctrl_r[fdsm_pkg::SYNC_EN_BIT];

  // odd periods are rounded down to even, and below two runs as two
  assign period_eff = (period_r < fdsm_pkg::MIN_PERIOD) ? fdsm_pkg::MIN_PERIOD
                                                        : {period_r[23:1], 1'b0};
  assign per_end    = (per_cnt_r == 24'h000000);
  assign peak_now   = (i_magnitude > peak_acc_r) ? i_magnitude : peak_acc_r;

  // period counter, restarted by a sync edge
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      per_cnt_r <= fdsm_pkg::RST_PERIOD - 24'h000001;
    end else if (sync_hit || per_end) begin
      per_cnt_r <= period_eff - 24'h000001;
    end else begin
      per_cnt_r <= per_cnt_r - 24'h000001;
    end
  end

  // peak detector
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      peak_acc_r <= 13'h0000;
      peak_res_r <= 13'h0000;
    end else if (!peak_en_r) begin
      peak_acc_r <= peak_acc_r;
    end else if (sync_hit) begin
      peak_acc_r <= i_magnitude;
    end else if (per_end) begin
      peak_res_r <= peak_now;
      peak_acc_r <= 13'h0000;
    end else begin
      peak_acc_r <= peak_now;
    end
  end

  // flag pin: force overrides the comparator
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_amp_flag_out_a <= 1'b0;
      fd_flag_d_r      <= 1'b0;
    end else begin
      fd_flag_d_r      <= fd_flag;
      o_amp_flag_out_a <= fd_ctrl_r[fdsm_pkg::FD_FORCE_BIT] ?
                          fd_ctrl_r[fdsm_pkg::FD_FVAL_BIT] : fd_flag;
    end
  end

  // interrupts: sticky, write one to clear, a new event wins over the clear
  assign irq_event = {per_end, sync_hit, fd_flag && !fd_flag_d_r};

  always_comb begin
    irq_status_nxt = irq_status_r;
    if (wr_hit(fdsm_pkg::IDX_IRQ_STATUS)) begin
      irq_status_nxt = irq_status_nxt & ~reg_bus.wr_data[2:0];
    end
    irq_status_nxt = irq_status_nxt | irq_event;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      irq_status_r <= 3'h0;
      irq_mask_r   <= 3'h0;
      o_irq        <= 1'b0;
    end else begin
      irq_status_r <= irq_status_nxt;
      if (wr_hit(fdsm_pkg::IDX_IRQ_MASK)) begin
        irq_mask_r <= reg_bus.wr_data[2:0];
      end
      o_irq <= |(irq_status_nxt & irq_mask_r);
    end
  end

  // read mux; reserved bits and unmapped indexes read zero
  always_comb begin
    rd_data = 8'h00;
    unique case (reg_bus.rd_idx)
      fdsm_pkg::IDX_FD_CTRL:     rd_data = fd_ctrl_r;
      fdsm_pkg::IDX_FD_UP_LO:    rd_data = up_lo_r;
      fdsm_pkg::IDX_FD_UP_HI:    rd_data = {3'h0, up_hi_r};
      fdsm_pkg::IDX_FD_LOW_LO:   rd_data = low_lo_r;
      fdsm_pkg::IDX_FD_LOW_HI:   rd_data = {3'h0, low_hi_r};
      fdsm_pkg::IDX_FD_DWELL_LO: rd_data = dwell_lo_r;
      fdsm_pkg::IDX_FD_DWELL_HI: rd_data = dwell_hi_r;
      fdsm_pkg::IDX_MON_SYNC:    rd_data = {6'h00, sync_ctrl_r};
      fdsm_pkg::IDX_MON_CTRL:    rd_data = {6'h00, peak_en_r, 1'b0};
      fdsm_pkg::IDX_MON_PER0:    rd_data = period_r[7:0];
      fdsm_pkg::IDX_MON_PER1:    rd_data = period_r[15:8];
      fdsm_pkg::IDX_MON_PER2:    rd_data = period_r[23:16];
      fdsm_pkg::IDX_IRQ_STATUS:  rd_data = {5'h00, irq_status_r};
      fdsm_pkg::IDX_IRQ_MASK:    rd_data = {5'h00, irq_mask_r};
      fdsm_pkg::IDX_PEAK_LO:     rd_data = peak_res_r[7:0];
      fdsm_pkg::IDX_PEAK_HI:     rd_data = {3'h0, peak_res_r[12:8]};
      default:                   rd_data = 8'h00;
    endcase
  end

  assign reg_bus.rd_data = rd_data;
endmodule : fdsm_top

// ---- verif/fdsm_assertions.sv ----
// checker: port-level properties of the amplitude watch block
`timescale 1ns/1ps
module fdsm_assertions (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_reset,
  // bus
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic [31:0] i_hwdata,
  input wire logic [31:0] o_hrdata,
  // converter side
  input wire logic [12:0] i_magnitude,
  input wire logic        o_amp_flag_out_a
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic        take;
  logic        pend_r;
  logic [9:0]  pidx_r;
  logic [3:0]  ctl_r;
  logic [12:0] up_r;
  logic [12:0] lo_r;
  assign take = i_hsel & i_hready & i_htrans[1] & (i_haddr[31:12] == 20'h00000);
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pend_r <= 1'b0;
      pidx_r <= 10'h000;
    end else begin
      pend_r <= take & i_hwrite;
      pidx_r <= i_haddr[11:2];
    end
  end
  // shadows land at the data phase edge, the same edge as the block's own registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctl_r <= 4'h0;
      up_r  <= 13'h0000;
      lo_r  <= 13'h0000;
    end else if (pend_r) begin
      case (pidx_r)
        fdsm_pkg::IDX_FD_CTRL:   ctl_r      <= i_hwdata[3:0];
        fdsm_pkg::IDX_FD_UP_LO:  up_r[7:0]  <= i_hwdata[7:0];
        fdsm_pkg::IDX_FD_UP_HI:  up_r[12:8] <= i_hwdata[4:0];
        fdsm_pkg::IDX_FD_LOW_LO: lo_r[7:0]  <= i_hwdata[7:0];
        fdsm_pkg::IDX_FD_LOW_HI: lo_r[12:8] <= i_hwdata[4:0];
        default: ;
      endcase
    end
  end
  sequence rd_at(logic [9:0] idx);
    take && !i_hwrite && i_haddr[11:2] == idx;
  endsequence
  a_up_hi_rsvd: assert property (
    rd_at(fdsm_pkg::IDX_FD_UP_HI) |=> o_hrdata[31:5] == 27'h0000000)
    else $error("upper high byte shows reserved bits");
  a_low_hi_rsvd: assert property (
    rd_at(fdsm_pkg::IDX_FD_LOW_HI) |=> o_hrdata[31:5] == 27'h0000000)
    else $error("lower high byte shows reserved bits");
  a_sync_rsvd: assert property (
    rd_at(fdsm_pkg::IDX_MON_SYNC) |=> o_hrdata[31:2] == 30'h00000000)
    else $error("sync control shows reserved bits");
  a_mon_ctl_rsvd: assert property (
    rd_at(fdsm_pkg::IDX_MON_CTRL) |=> o_hrdata[31:2] == 30'h00000000)
    else $error("monitor control shows reserved bits");
  a_rise_over_upper: assert property (
    $rose(o_amp_flag_out_a) && !ctl_r[3] && !$past(ctl_r[3]) && !$past(ctl_r[3], 2)
    |-> $past(i_magnitude, 2) > $past(up_r, 2))
    else $error("flag rose without magnitude above upper");
  a_fall_below_lower: assert property (
    $fell(o_amp_flag_out_a) && $past(ctl_r[0], 2) && !ctl_r[3] && !$past(ctl_r[3])
    && !$past(ctl_r[3], 2) |-> $past(i_magnitude, 2) < $past(lo_r, 2))
    else $error("flag fell while magnitude not below lower");
  a_force_value: assert property (
    $past(ctl_r[3]) |-> o_amp_flag_out_a == $past(ctl_r[2]))
    else $error("forced pin differs from force value");
  a_off_when_idle: assert property (
    (!ctl_r[0] && !ctl_r[3]) [*4] |-> !o_amp_flag_out_a)
    else $error("flag high while detection disabled");
  c_flag_rise: cover property ($rose(o_amp_flag_out_a));
  c_force_high: cover property (ctl_r[3] && o_amp_flag_out_a);
  c_sync_read: cover property (rd_at(fdsm_pkg::IDX_MON_SYNC));
endmodule : fdsm_assertions

// ---- verif/fdsm_gain_ctrl_model.sv ----
// gain control model: counts rising edges of the amplitude flag pin
`timescale 1ns/1ps
module fdsm_gain_ctrl_model (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset,
  // flag pin
  input  wire logic i_flag,
  output int        o_rises
);
  logic last_r;
  // a real loop would step attenuation on each rise; counting them is enough here
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      last_r  <= 1'b0;
      o_rises <= 0;
    end else begin
      last_r <= i_flag;
      if (i_flag && !last_r) begin
        o_rises <= o_rises + 1;
      end
    end
  end
endmodule : fdsm_gain_ctrl_model

// ---- verif/test_fast_detect_signal_monitor.sv ----
// testbench: register, flag pin, sync and peak scenarios for the amplitude watch block
`timescale 1ns/1ps
module test_fast_detect_signal_monitor;
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        i_hsel = 1'b0;
  logic [31:0] i_haddr = 32'h0;
  logic [1:0]  i_htrans = 2'h0;
  logic        i_hwrite = 1'b0;
  logic [31:0] i_hwdata = 32'h0;
  logic [12:0] i_magnitude = 13'h0;
  logic        i_sysref = 1'b0;
  logic        i_sysref_en = 1'b0;
  logic [31:0] o_hrdata;
  logic        o_hreadyout, o_hresp, o_amp_flag_out_a, o_irq;
  int          mismatches = 0;
  int          compares = 0;
  int          rises;
  logic [31:0] r;
  always #50 i_clk = ~i_clk;
  fdsm_top fdsm_top_inst (.i_clk(i_clk), .i_reset(i_reset), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hsize(3'h2), .i_hwrite(i_hwrite), .i_hready(o_hreadyout),
    .i_hwdata(i_hwdata), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_magnitude(i_magnitude), .i_sysref(i_sysref), .i_sysref_en(i_sysref_en),
    .o_amp_flag_out_a(o_amp_flag_out_a), .o_irq(o_irq));
  fdsm_gain_ctrl_model fdsm_gain_ctrl_model_inst (.i_clk(i_clk), .i_reset(i_reset),
    .i_flag(o_amp_flag_out_a), .o_rises(rises));
  task automatic results;
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc
  // a stuck bus ends the run instead of hanging it
  task automatic wait_ready;
    int n;
    n = 0;
    @(posedge i_clk);
    while (o_hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        mismatches++;
        results();
      end
      @(posedge i_clk);
    end
  endtask : wait_ready
  task automatic xfer(input logic wr, input logic [9:0] idx, input logic [7:0] d);
    i_hsel   <= 1'b1;
    i_haddr  <= {20'h0, idx, 2'b00};
    i_htrans <= 2'b10;
    i_hwrite <= wr;
    wait_ready();
    i_hsel   <= 1'b0;
    i_htrans <= 2'b00;
    i_hwdata <= {24'h0, d};
    wait_ready();
    r = o_hrdata;
    check("hresp okay", 32'(o_hresp), 32'h0);
    // two idle edges: outputs that a write launches have settled before any check reads them
    @(posedge i_clk);
    @(posedge i_clk);
  endtask : xfer
  task automatic rdc(input string name, input logic [9:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    check(name, r, {24'h0, exp});
  endtask : rdc
  task automatic sync_chk(input string name, input logic exp);
    xfer(1'b1, fdsm_pkg::IDX_IRQ_STATUS, 8'h07);
    i_sysref <= 1'b1;
    cyc(4);
    i_sysref <= 1'b0;
    // back-to-back calls put sysref edges exactly one 128-cycle monitor period apart
    cyc(116);
    xfer(1'b0, fdsm_pkg::IDX_IRQ_STATUS, 8'h00);
    check(name, r[1], exp);
  endtask : sync_chk
  initial begin
    cyc(12);
    i_reset <= 1'b0;
    cyc(1);
    for (int i = 0; i < 6; i++) begin
      rdc("fd reset byte", fdsm_pkg::IDX_FD_UP_LO + 10'(i), 8'h00);
    end
    for (int i = 0; i < 5; i++) begin
      rdc("mon reset byte", fdsm_pkg::IDX_MON_SYNC + 10'(i), (i == 2) ? 8'h80 : 8'h00);
    end
    rdc("unmapped", 10'h3ff, 8'h00);
    xfer(1'b1, fdsm_pkg::IDX_FD_UP_HI, 8'hff);
    rdc("upper high", fdsm_pkg::IDX_FD_UP_HI, 8'h1f);
    xfer(1'b1, fdsm_pkg::IDX_FD_LOW_HI, 8'hff);
    rdc("lower high", fdsm_pkg::IDX_FD_LOW_HI, 8'h1f);
    xfer(1'b1, fdsm_pkg::IDX_FD_UP_LO, 8'h34);
    xfer(1'b1, fdsm_pkg::IDX_FD_UP_HI, 8'h12);
    xfer(1'b1, fdsm_pkg::IDX_FD_LOW_HI, 8'h01);
    xfer(1'b1, fdsm_pkg::IDX_FD_DWELL_LO, 8'h03);
    xfer(1'b1, fdsm_pkg::IDX_FD_DWELL_HI, 8'h01);
    xfer(1'b1, fdsm_pkg::IDX_IRQ_MASK, 8'h01);
    i_magnitude <= 13'h1234;
    xfer(1'b1, fdsm_pkg::IDX_FD_CTRL, 8'h01);
    cyc(4);
    check("flag at upper", o_amp_flag_out_a, 1'b0);
    i_magnitude <= 13'h1235;
    cyc(3);
    check("flag above upper", o_amp_flag_out_a, 1'b1);
    xfer(1'b0, fdsm_pkg::IDX_IRQ_STATUS, 8'h00);
    check("flag status", r[0], 1'b1);
    check("irq raised", o_irq, 1'b1);
    xfer(1'b1, fdsm_pkg::IDX_IRQ_MASK, 8'h00);
    check("irq masked", o_irq, 1'b0);
    xfer(1'b1, fdsm_pkg::IDX_IRQ_MASK, 8'h01);
    check("irq unmasked", o_irq, 1'b1);
    xfer(1'b1, fdsm_pkg::IDX_IRQ_STATUS, 8'h01);
    check("irq cleared", o_irq, 1'b0);
    i_magnitude <= 13'h0100;
    cyc(8);
    check("flag at lower", o_amp_flag_out_a, 1'b1);
    i_magnitude <= 13'h00ff;
    cyc(200);
    i_magnitude <= 13'h0100;
    cyc(1);
    i_magnitude <= 13'h00ff;
    cyc(255);
    check("flag dwell restarted", o_amp_flag_out_a, 1'b1);
    cyc(8);
    check("flag released", o_amp_flag_out_a, 1'b0);
    xfer(1'b1, fdsm_pkg::IDX_FD_CTRL, 8'h0c);
    check("forced high", o_amp_flag_out_a, 1'b1);
    xfer(1'b1, fdsm_pkg::IDX_FD_CTRL, 8'h08);
    check("forced low", o_amp_flag_out_a, 1'b0);
    xfer(1'b1, fdsm_pkg::IDX_FD_CTRL, 8'h00);
    check("pin rises", rises, 32'h2);
    xfer(1'b1, fdsm_pkg::IDX_MON_SYNC, 8'h01);
    sync_chk("sync input off", 1'b0);
    i_sysref_en <= 1'b1;
    sync_chk("sync continuous", 1'b1);
    sync_chk("sync continuous again", 1'b1);
    rdc("sync kept", fdsm_pkg::IDX_MON_SYNC, 8'h01);
    xfer(1'b1, fdsm_pkg::IDX_MON_SYNC, 8'h03);
    sync_chk("sync next", 1'b1);
    rdc("sync cleared", fdsm_pkg::IDX_MON_SYNC, 8'h02);
    sync_chk("sync ignored", 1'b0);
    xfer(1'b1, fdsm_pkg::IDX_MON_PER0, 8'h10);
    i_magnitude <= 13'h0abc;
    xfer(1'b1, fdsm_pkg::IDX_MON_CTRL, 8'h02);
    // the running count may still hold up to one old 128-cycle period before the new one
    cyc(150);
    rdc("peak low", fdsm_pkg::IDX_PEAK_LO, 8'hbc);
    rdc("peak high", fdsm_pkg::IDX_PEAK_HI, 8'h0a);
    xfer(1'b1, fdsm_pkg::IDX_MON_CTRL, 8'h00);
    i_magnitude <= 13'h0fff;
    cyc(40);
    rdc("peak held", fdsm_pkg::IDX_PEAK_LO, 8'hbc);
    results();
  end
endmodule : test_fast_detect_signal_monitor
bind fdsm_top fdsm_assertions fdsm_assertions_inst (.i_clk(i_clk), .i_reset(i_reset),
  .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
  .i_hready(i_hready), .i_hwdata(i_hwdata), .o_hrdata(o_hrdata), .i_magnitude(i_magnitude),
  .o_amp_flag_out_a(o_amp_flag_out_a));
